// file: include/cpac_map.svh
`ifndef CPAC_MAP_SVH
`define CPAC_MAP_SVH

// Register offsets on the control port
`define CPAC_OFS_POWER          6'h05
`define CPAC_OFS_AUDIO3         6'h06

// Reset values of the stored parts of both registers
`define CPAC_POWER_RST          16'hffc0
`define CPAC_AUDIO3_RST         16'h0000

// Power control register field positions
`define CPAC_PWR_OFF_MSB        15
`define CPAC_PWR_OFF_LSB        6
`define CPAC_PWR_HANDSET_BIAS   15
`define CPAC_PWR_HEADSET_BIAS   14
`define CPAC_PWR_SIDETONE       13
`define CPAC_PWR_SPEAKER_ONE    12
`define CPAC_PWR_SPEAKER_TWO    11
`define CPAC_PWR_DAC            10
`define CPAC_PWR_ADC            9
`define CPAC_PWR_VGND           8
`define CPAC_PWR_CHARGE_OUT     7
`define CPAC_PWR_LOUDSPEAKER    6
`define CPAC_PWR_ADC_DONE       5
`define CPAC_PWR_LDAC_DONE      4
`define CPAC_PWR_RDAC_DONE      3
`define CPAC_PWR_SIDETONE_DONE  2
`define CPAC_PWR_EFFECTS        1
`define CPAC_PWR_DEEMPH         0

// Audio control three field positions
`define CPAC_A3_VOL_MSB         15
`define CPAC_A3_VOL_LSB         14
`define CPAC_A3_RATE            13
`define CPAC_A3_XFER            12
`define CPAC_A3_ROLE            11
`define CPAC_A3_RSV_RO_MSB      10
`define CPAC_A3_RSV_RO_LSB      9
`define CPAC_A3_ADC_OVF         8
`define CPAC_A3_LDAC_OVF        7
`define CPAC_A3_RDAC_OVF        6
`define CPAC_A3_RSV_RW_MSB      5
`define CPAC_A3_RSV_RW_LSB      4
`define CPAC_A3_CLIP_STEP       3
`define CPAC_A3_REV_MSB         2
`define CPAC_A3_REV_LSB         0

// Done flags read 1 out of reset
`define CPAC_DONE_RST           4'hf

`endif

// file: include/cpac_pkg.sv
package cpac_pkg;

    // Volume link choices; 2'b11 behaves as independent
    typedef enum logic [1:0] {
        CPAC_VOL_INDEP     = 2'h0,
        CPAC_VOL_LEFT_FROM = 2'h1,
        CPAC_VOL_RIGHT_FROM = 2'h2,
        CPAC_VOL_INDEP_ALT = 2'h3
    } cpac_vol_t;

    // Writable fields of the power control register
    typedef struct packed {
        logic [9:0] blk_off;
        logic       effects_filter_enable;
        logic       deemphasis_enable;
    } cpac_power_t;

    // Writable fields of audio control three
    typedef struct packed {
        cpac_vol_t  volume_link_select;
        logic       reference_rate_select;
        logic       transfer_mode_select;
        logic       role_select;
        logic [1:0] reserved_rw;
        logic       agc_clip_step;
    } cpac_audio3_t;

    // State of the register bank apart from the overflow flags, which u_ovf keeps
    typedef struct packed {
        cpac_power_t  power;
        cpac_audio3_t audio3;
        logic [3:0]   done;
        logic [15:0]  rdata;
        logic         rvalid;
    } cpac_state_t;

endpackage

// file: include/cpac_flag_if.sv
`timescale 1ns/1ps
interface cpac_flag_if #(parameter int NUM = 3);
    logic [NUM-1:0] set_evt;
    logic           clear;
    logic [NUM-1:0] flags;

    modport owner (output set_evt, output clear, input flags);
    modport keeper (input set_evt, input clear, output flags);
endinterface

// file: core/cpac_flag.sv
`timescale 1ns/1ps
module cpac_flag
    import cpac_pkg::*;
#(
    parameter int NUM = 3
) (
    input  wire logic  mclk,
    input  wire logic  arst_n,
    cpac_flag_if.keeper fl
);
    typedef struct packed {
        logic [NUM-1:0] flags;
    } cpac_flag_st_t;

    cpac_flag_st_t st_ff;
    cpac_flag_st_t nxt_st;

    // Sticky per-bit flags; a new event in the clearing cycle survives
    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < NUM; i++) begin
            if (fl.set_evt[i]) begin
                nxt_st.flags[i] = 1'b1;
            end else if (fl.clear) begin
                nxt_st.flags[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fl.flags = st_ff.flags;
endmodule

// file: core/cpac_regs.sv
`timescale 1ns/1ps
`include "cpac_map.svh"
// Summary of operation
// - Power bits 15..6 power a block down when 1, up when 0; reset 1.
// - All ten power bits set means the whole codec section is down.
// - Bit 5 reads 1 when ADC power-down has finished; reset 1.
// - Bits 4 and 3 report left and right DAC power-down done; reset 1.
// - Bit 2 reads 1 when sidetone power-down has finished; reset 1.
// - Bit 1 enables the effects filter when 1, bypasses when 0; reset 0.
// - Bit 0 enables the de-emphasis filter when 1; reset 0.
// - Volume link: 00/11 independent, 01 left follows right, 10 right follows left.
// - Bit 13 picks 48.0 kHz at 0, 44.1 kHz at 1 for derived settings.
// - Bit 12 picks continuous transfer at 0, 256-s mode at 1; reset 0.
// - Bit 11 makes the codec slave at 0, master at 1; reset slave.
// - Bit 8 sets on ADC saturation and clears after the register read.
// - Bit 7 sets on left DAC saturation and clears after read.
// - Bit 6 sets on right DAC saturation and clears after read.
// - AGC clip stepping bit 3 acts only while AGC is selected; reset 0.
// - Bits 2..0 of audio control three read the revision code.
module cpac_regs
    import cpac_pkg::*;
#(
    parameter int         AW            = 6,
    parameter logic [2:0] REVISION_CODE = 3'h1  // Arbitrary value
) (
    input  wire logic          mclk,
    input  wire logic          arst_n,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [15:0]   reg_wdata,
    output logic [15:0]        reg_rdata,
    output logic               reg_rvalid,
    input  wire logic          adc_off_done_in,
    input  wire logic          left_dac_off_done_in,
    input  wire logic          right_dac_off_done_in,
    input  wire logic          sidetone_off_done_in,
    input  wire logic          adc_overflow_evt,
    input  wire logic          left_dac_overflow_evt,
    input  wire logic          right_dac_overflow_evt,
    input  wire logic          agc_selected,
    input  wire logic [7:0]    left_vol_setting,
    input  wire logic [7:0]    right_vol_setting,
    output logic               handset_bias_off,
    output logic               headset_bias_off,
    output logic               sidetone_off,
    output logic               speaker_one_off,
    output logic               speaker_two_off,
    output logic               dac_off,
    output logic               adc_off,
    output logic               virtual_ground_off,
    output logic               charge_out_off,
    output logic               loudspeaker_off,
    output logic               codec_all_off,
    output logic               effects_filter_enable,
    output logic               deemphasis_enable,
    output logic [7:0]         left_vol_applied,
    output logic [7:0]         right_vol_applied,
    output logic               reference_rate_select,
    output logic               transfer_mode_select,
    output logic               role_select,
    output logic               agc_clip_step,
    output logic               agc_clip_step_active
);
    cpac_state_t st_ff;
    cpac_state_t nxt_st;

    // Reset words held as constants so their fields can be sliced
    localparam logic [15:0] POWER_RST  = `CPAC_POWER_RST;
    localparam logic [15:0] AUDIO3_RST = `CPAC_AUDIO3_RST;

    logic        hit_power;
    logic        hit_audio3;
    logic        wr_power;
    logic        wr_audio3;
    logic        rd_audio3;
    logic [15:0] power_view;
    logic [15:0] audio3_view;
    logic [2:0]  ovf_flags;

    cpac_flag_if #(.NUM(3)) ovf_if ();

    // Address decode; anything else is ignored on write and reads zero
    assign hit_power  = (reg_addr == AW'(`CPAC_OFS_POWER));
    assign hit_audio3 = (reg_addr == AW'(`CPAC_OFS_AUDIO3));
    assign wr_power   = reg_wr && hit_power;
    assign wr_audio3  = reg_wr && hit_audio3;
    assign rd_audio3  = reg_rd && hit_audio3;

    // Overflow events feed the sticky keeper; a read of the register clears
    assign ovf_if.set_evt = {adc_overflow_evt,
                             left_dac_overflow_evt,
                             right_dac_overflow_evt};
    assign ovf_if.clear   = rd_audio3;
    assign ovf_flags      = ovf_if.flags;

    cpac_flag #(
        .NUM (3)
    ) u_ovf (
        .mclk   (mclk),
        .arst_n (arst_n),
        .fl     (ovf_if.keeper)
    );

    // Read view of the power control register
    always_comb begin
        power_view = '0;
        power_view[`CPAC_PWR_OFF_MSB:`CPAC_PWR_OFF_LSB] = st_ff.power.blk_off;
        power_view[`CPAC_PWR_ADC_DONE]      = st_ff.done[3];
        power_view[`CPAC_PWR_LDAC_DONE]     = st_ff.done[2];
        power_view[`CPAC_PWR_RDAC_DONE]     = st_ff.done[1];
        power_view[`CPAC_PWR_SIDETONE_DONE] = st_ff.done[0];
        power_view[`CPAC_PWR_EFFECTS]       = st_ff.power.effects_filter_enable;
        power_view[`CPAC_PWR_DEEMPH]        = st_ff.power.deemphasis_enable;
    end

    // Read view of audio control three; reserved read-only pair stays zero
    always_comb begin
        audio3_view = '0;
        audio3_view[`CPAC_A3_VOL_MSB:`CPAC_A3_VOL_LSB] = st_ff.audio3.volume_link_select;
        audio3_view[`CPAC_A3_RATE]      = st_ff.audio3.reference_rate_select;
        audio3_view[`CPAC_A3_XFER]      = st_ff.audio3.transfer_mode_select;
        audio3_view[`CPAC_A3_ROLE]      = st_ff.audio3.role_select;
        audio3_view[`CPAC_A3_RSV_RO_MSB:`CPAC_A3_RSV_RO_LSB] = 2'h0;
        audio3_view[`CPAC_A3_ADC_OVF]   = ovf_flags[2];
        audio3_view[`CPAC_A3_LDAC_OVF]  = ovf_flags[1];
        audio3_view[`CPAC_A3_RDAC_OVF]  = ovf_flags[0];
        audio3_view[`CPAC_A3_RSV_RW_MSB:`CPAC_A3_RSV_RW_LSB] = st_ff.audio3.reserved_rw;
        audio3_view[`CPAC_A3_CLIP_STEP] = st_ff.audio3.agc_clip_step;
        audio3_view[`CPAC_A3_REV_MSB:`CPAC_A3_REV_LSB] = REVISION_CODE;
    end

    // Next state: writable fields take write data, read-only bits ignore it
    always_comb begin
        nxt_st = st_ff;

        // Done flags follow the analog blocks with one register stage
        nxt_st.done = {adc_off_done_in,
                       left_dac_off_done_in,
                       right_dac_off_done_in,
                       sidetone_off_done_in};

        if (wr_power) begin
            nxt_st.power.blk_off =
                reg_wdata[`CPAC_PWR_OFF_MSB:`CPAC_PWR_OFF_LSB];
            nxt_st.power.effects_filter_enable = reg_wdata[`CPAC_PWR_EFFECTS];
            nxt_st.power.deemphasis_enable     = reg_wdata[`CPAC_PWR_DEEMPH];
            // Bits 5..2 are status and drop the written value
        end

        if (wr_audio3) begin
            nxt_st.audio3.volume_link_select =
                cpac_vol_t'(reg_wdata[`CPAC_A3_VOL_MSB:`CPAC_A3_VOL_LSB]);
            nxt_st.audio3.reference_rate_select = reg_wdata[`CPAC_A3_RATE];
            nxt_st.audio3.transfer_mode_select  = reg_wdata[`CPAC_A3_XFER];
            nxt_st.audio3.role_select           = reg_wdata[`CPAC_A3_ROLE];
            nxt_st.audio3.reserved_rw =
                reg_wdata[`CPAC_A3_RSV_RW_MSB:`CPAC_A3_RSV_RW_LSB];
            nxt_st.audio3.agc_clip_step         = reg_wdata[`CPAC_A3_CLIP_STEP];
            // Flags, reserved read-only and revision keep their values
        end

        // Read data is captured before any clear-on-read takes effect
        nxt_st.rvalid = reg_rd;
        if (reg_rd) begin
            if (hit_power) begin
                nxt_st.rdata = power_view;
            end else if (hit_audio3) begin
                nxt_st.rdata = audio3_view;
            end else begin
                nxt_st.rdata = 16'h0000;
            end
        end
    end

    // Single state register; power bits come up powered down
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff.power  <= cpac_power_t'({POWER_RST[15:6],
                                           POWER_RST[1:0]});
            st_ff.audio3 <= cpac_audio3_t'({AUDIO3_RST[15:11],
                                            AUDIO3_RST[5:3]});
            st_ff.done   <= `CPAC_DONE_RST;
            st_ff.rdata  <= 16'h0000;
            st_ff.rvalid <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata  = st_ff.rdata;
    assign reg_rvalid = st_ff.rvalid;

    // Per-block power-down controls straight from the register
    assign handset_bias_off   = st_ff.power.blk_off[9];
    assign headset_bias_off   = st_ff.power.blk_off[8];
    assign sidetone_off       = st_ff.power.blk_off[7];
    assign speaker_one_off    = st_ff.power.blk_off[6];
    assign speaker_two_off    = st_ff.power.blk_off[5];
    assign dac_off            = st_ff.power.blk_off[4];
    assign adc_off            = st_ff.power.blk_off[3];
    assign virtual_ground_off = st_ff.power.blk_off[2];
    assign charge_out_off     = st_ff.power.blk_off[1];
    assign loudspeaker_off    = st_ff.power.blk_off[0];

    // Whole-section shutdown only when every block bit is set
    assign codec_all_off = &st_ff.power.blk_off;

    assign effects_filter_enable = st_ff.power.effects_filter_enable;
    assign deemphasis_enable     = st_ff.power.deemphasis_enable;

    // Volume source selection; the alternate code falls back to independent
    always_comb begin
        left_vol_applied  = left_vol_setting;
        right_vol_applied = right_vol_setting;
        unique case (st_ff.audio3.volume_link_select)
            CPAC_VOL_LEFT_FROM: begin
                left_vol_applied = right_vol_setting;
            end
            CPAC_VOL_RIGHT_FROM: begin
                right_vol_applied = left_vol_setting;
            end
            CPAC_VOL_INDEP, CPAC_VOL_INDEP_ALT: begin
                left_vol_applied  = left_vol_setting;
                right_vol_applied = right_vol_setting;
            end
        endcase
    end

    // Rate choice steers de-emphasis, AGC timing and touch ADC dividers
    // outside; the host is trusted to avoid 44.1 above 48 kHz
    assign reference_rate_select = st_ff.audio3.reference_rate_select;
    assign transfer_mode_select  = st_ff.audio3.transfer_mode_select;
    assign role_select           = st_ff.audio3.role_select;

    // Clip stepping is stored always but acts only while AGC is selected
    assign agc_clip_step        = st_ff.audio3.agc_clip_step;
    assign agc_clip_step_active = st_ff.audio3.agc_clip_step && agc_selected;
endmodule

// file: verif/cpac_regs_sva.sv
`timescale 1ns/1ps
module cpac_regs_sva
    import cpac_pkg::*;
#(
    parameter int         AW            = 6,
    parameter logic [2:0] REVISION_CODE = 3'h1
) (
    input wire logic          mclk,
    input wire logic          arst_n,
    input wire logic [AW-1:0] reg_addr,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [15:0]   reg_wdata,
    input wire logic [15:0]   reg_rdata,
    input wire logic          reg_rvalid,
    input wire logic          adc_off_done_in,
    input wire logic          left_dac_off_done_in,
    input wire logic          right_dac_off_done_in,
    input wire logic          sidetone_off_done_in,
    input wire logic          adc_overflow_evt,
    input wire logic          left_dac_overflow_evt,
    input wire logic          right_dac_overflow_evt,
    input wire logic          agc_selected,
    input wire logic          handset_bias_off,
    input wire logic          headset_bias_off,
    input wire logic          sidetone_off,
    input wire logic          speaker_one_off,
    input wire logic          speaker_two_off,
    input wire logic          dac_off,
    input wire logic          adc_off,
    input wire logic          virtual_ground_off,
    input wire logic          charge_out_off,
    input wire logic          loudspeaker_off,
    input wire logic          codec_all_off,
    input wire logic          effects_filter_enable,
    input wire logic          deemphasis_enable,
    input wire logic          reference_rate_select,
    input wire logic          transfer_mode_select,
    input wire logic          role_select,
    input wire logic          agc_clip_step,
    input wire logic          agc_clip_step_active
);
    logic [9:0] pwr_bits;
    logic [3:0] done_in;
    logic [2:0] ovf_evt;
    // Gathered in register bit order so reads compare in one step
    assign pwr_bits = {handset_bias_off, headset_bias_off, sidetone_off, speaker_one_off,
                       speaker_two_off, dac_off, adc_off, virtual_ground_off, charge_out_off,
                       loudspeaker_off};
    assign done_in  = {adc_off_done_in, left_dac_off_done_in, right_dac_off_done_in,
                       sidetone_off_done_in};
    assign ovf_evt  = {adc_overflow_evt, left_dac_overflow_evt, right_dac_overflow_evt};

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_power_write: assert property (reg_wr && reg_addr == 6'h05 |=>
        pwr_bits == $past(reg_wdata[15:6])) else $error("power bits differ from write");
    chk_all_off: assert property (codec_all_off == &pwr_bits)
        else $error("codec_all_off does not match power bits");
    chk_power_readback: assert property (reg_rd && reg_addr == 6'h05 |=>
        reg_rdata[15:2] == {$past(pwr_bits), $past(done_in, 2)})
        else $error("power register read is wrong");
    chk_filter_write: assert property (reg_wr && reg_addr == 6'h05 |=>
        {effects_filter_enable, deemphasis_enable} == $past(reg_wdata[1:0]))
        else $error("filter enables differ from write");
    chk_mode_write: assert property (reg_wr && reg_addr == 6'h06 |=>
        {reference_rate_select, transfer_mode_select, role_select, agc_clip_step}
        == {$past(reg_wdata[13:11]), $past(reg_wdata[3])}) else $error("mode bits wrong");
    chk_clip_gate: assert property (agc_clip_step_active == (agc_clip_step && agc_selected))
        else $error("clip step active without agc");
    chk_fixed_bits: assert property (reg_rvalid && $past(reg_addr) == 6'h06 |->
        reg_rdata[10:9] == 2'h0 && reg_rdata[2:0] == REVISION_CODE)
        else $error("reserved or revision bits wrong");
    chk_ovf_sticky: assert property (reg_rd && reg_addr == 6'h06 |=>
        (reg_rdata[8:6] & $past(ovf_evt, 2)) == $past(ovf_evt, 2))
        else $error("overflow flag lost before read");
    chk_ovf_clear: assert property ((reg_rd && reg_addr == 6'h06 && ovf_evt == 3'h0) ##1
        (reg_rd && reg_addr == 6'h06) |=> reg_rdata[8:6] == 3'h0)
        else $error("overflow flag not cleared by read");
    chk_unmapped_read: assert property (reg_rd && reg_addr != 6'h05 && reg_addr != 6'h06 |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule

bind cpac_regs cpac_regs_sva #(.AW(AW), .REVISION_CODE(REVISION_CODE)) sva_u (.*);

// file: verif/cpac_host_model.sv
`timescale 1ns/1ps
module cpac_host_model (
    input  wire logic   mclk,
    output logic [5:0]  reg_addr,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [15:0] reg_wdata
);
    // Quiet port at time zero
    initial begin
        reg_addr  = 6'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // One request per call; strobes stay up so calls may run back to back
    // Rate choice is left to the caller, both settings are legal here
    task automatic access(input logic wr, input logic rd, input logic [5:0] a,
                          input logic [15:0] d);
        @(negedge mclk);
        reg_wr    <= wr;
        reg_rd    <= rd;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
    endtask

    // Drop strobes and scramble qualifiers so stale values never look valid
    task automatic idle();
        @(negedge mclk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask
endmodule

// file: verif/test_codec_power_audio_ctrl_regs.sv
`timescale 1ns/1ps
module test_codec_power_audio_ctrl_regs;
    import cpac_pkg::*;
    localparam logic [2:0] REV = 3'h5;  // Arbitrary revision value
    logic        mclk, arst_n, reg_wr, reg_rd, reg_rvalid, agc_selected;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d, pw;
    logic [3:0]  done_in;
    logic [2:0]  ovf_evt;
    logic [7:0]  lvol, rvol, lapp, rapp;
    logic [9:0]  pwr_out;
    logic        all_off, eff, deem, rate, xfer, role, clip, clip_act;
    logic [15:0] exp_q[$];
    int          error_cnt, n_checks, cyc;
    int          seed = 32'h6372d322;

    cpac_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    cpac_regs #(.AW(6), .REVISION_CODE(REV)) dut_u (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_off_done_in(done_in[3]),
        .left_dac_off_done_in(done_in[2]), .right_dac_off_done_in(done_in[1]),
        .sidetone_off_done_in(done_in[0]), .adc_overflow_evt(ovf_evt[2]),
        .left_dac_overflow_evt(ovf_evt[1]), .right_dac_overflow_evt(ovf_evt[0]),
        .agc_selected(agc_selected), .left_vol_setting(lvol), .right_vol_setting(rvol),
        .handset_bias_off(pwr_out[9]), .headset_bias_off(pwr_out[8]),
        .sidetone_off(pwr_out[7]), .speaker_one_off(pwr_out[6]),
        .speaker_two_off(pwr_out[5]), .dac_off(pwr_out[4]), .adc_off(pwr_out[3]),
        .virtual_ground_off(pwr_out[2]), .charge_out_off(pwr_out[1]),
        .loudspeaker_off(pwr_out[0]), .codec_all_off(all_off),
        .effects_filter_enable(eff), .deemphasis_enable(deem), .left_vol_applied(lapp),
        .right_vol_applied(rapp), .reference_rate_select(rate), .transfer_mode_select(xfer),
        .role_select(role), .agc_clip_step(clip), .agc_clip_step_active(clip_act));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        host_u.access(1'b1, 1'b0, a, v);
    endtask

    // The expected word is noted before the request goes out
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, 1'b1, a, 16'h0000);
    endtask

    task automatic finish_test();
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Read data stands one cycle; the falling edge sees it settled
    always @(negedge mclk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check("unasked read", 16'hxxxx, reg_rdata);
            else check("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("Error run length expected 5000 seen more");
            finish_test();
        end
    end

    initial begin
        arst_n = 1'b0;
        done_in = 4'hf;
        ovf_evt = 3'h0;
        agc_selected = 1'b0;
        lvol = 8'h11;
        rvol = 8'h22;
        repeat (8) @(posedge mclk);
        @(negedge mclk) arst_n = 1'b1;
        // Reset values
        check("codec_all_off", 16'h0001, {15'h0, all_off});
        rd(6'h05, 16'hfffc);
        rd(6'h06, {13'h0000, REV});
        host_u.idle();
        // Power register, both extremes first, then random words
        for (int i = 0; i < 12; i++) begin
            pw = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
            done_in = 4'($random(seed));
            wr(6'h05, pw);
            rd(6'h05, {pw[15:6], done_in, pw[1:0]});
            host_u.idle();
            check("power outputs", {6'h00, pw[15:6]}, {6'h00, pwr_out});
            check("codec_all_off", {15'h0, &pw[15:6]}, {15'h0, all_off});
            check("filter enables", {14'h0, pw[1:0]}, {14'h0, eff, deem});
        end
        // Audio control three, every volume link code four times
        for (int i = 0; i < 16; i++) begin
            d = 16'($random(seed));
            d[15:14] = i[1:0];
            lvol = 8'($random(seed));
            rvol = 8'($random(seed));
            agc_selected = 1'($random(seed));
            wr(6'h06, d);
            rd(6'h06, {d[15:11], 5'h00, d[5:3], REV});
            host_u.idle();
            check("left volume", {8'h00, (i[1:0] == 2'h1) ? rvol : lvol}, {8'h00, lapp});
            check("right volume", {8'h00, (i[1:0] == 2'h2) ? lvol : rvol}, {8'h00, rapp});
            check("mode outputs", {12'h000, d[13:11], d[3]},
                  {12'h000, rate, xfer, role, clip});
            check("clip active", {15'h0, d[3] & agc_selected}, {15'h0, clip_act});
        end
        // One pulse per saturation source, then two reads back to back
        for (int k = 0; k < 3; k++) begin
            ovf_evt = 3'h1 << k;
            @(negedge mclk);
            ovf_evt = 3'h0;
            rd(6'h06, {d[15:11], 2'h0, 3'(3'h1 << k), d[5:3], REV});
            rd(6'h06, {d[15:11], 5'h00, d[5:3], REV});
            host_u.idle();
        end
        // Unmapped place: write ignored, read returns zero
        wr(6'h07, 16'hffff);
        rd(6'h07, 16'h0000);
        rd(6'h05, {pw[15:6], done_in, pw[1:0]});
        rd(6'h06, {d[15:11], 5'h00, d[5:3], REV});
        host_u.idle();
        repeat (3) @(negedge mclk);
        check("pending reads", 16'h0000, 16'(exp_q.size()));
        finish_test();
    end
endmodule
